// ### rtl/awt_pkg.sv
// Package with constants and types of the auto wake-up from halt timer.
package awt_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  AWT_IDX_PRESCALE    = 8'h49;
    localparam logic [7:0]  AWT_IDX_CTRL_STATUS = 8'h4A;
    localparam logic [7:0]  AWT_IDX_IRQ_STATUS  = 8'h4B;
    localparam logic [7:0]  AWT_IDX_IRQ_MASK    = 8'h4C;
    localparam logic [11:0] AWT_ADDR_PRESCALE    = {2'h0, AWT_IDX_PRESCALE, 2'h0};
    localparam logic [11:0] AWT_ADDR_CTRL_STATUS = {2'h0, AWT_IDX_CTRL_STATUS, 2'h0};
    localparam logic [11:0] AWT_ADDR_IRQ_STATUS  = {2'h0, AWT_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] AWT_ADDR_IRQ_MASK    = {2'h0, AWT_IDX_IRQ_MASK, 2'h0};

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          AWT_BIT_ENABLE   = 0;
    localparam int          AWT_BIT_MEASURE  = 1;
    localparam int          AWT_BIT_FLAG     = 2;
    localparam int          AWT_IRQ_WAKE     = 0;
    localparam int          AWT_IRQ_EARLY    = 1;
    localparam int          AWT_IRQ_WDG      = 2;
    localparam logic [7:0]  AWT_RST_PRESCALE = 8'hFF;
    localparam logic [7:0]  AWT_RST_CTRL     = 8'h00;
    localparam logic [2:0]  AWT_RST_IRQ      = 3'h0;
    localparam logic [7:0]  AWT_PRESCALE_BAD = 8'h00;
    localparam logic [7:0]  AWT_HALT_OPCODE  = 8'h8E;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [5:0]  AWT_DIV_LAST      = 6'h3F;
    localparam int          AWT_STAB_CYCLES   = 64;
    localparam int          AWT_CLK_PERIOD_NS = 50;
    localparam int          AWT_RC_START_NS   = 10000;
    localparam int          AWT_RC_START_CYC  = (AWT_RC_START_NS + AWT_CLK_PERIOD_NS - 1) / AWT_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        AWT_RUN        = 3'h0,
        AWT_RC_START   = 3'h1,
        AWT_COUNT      = 3'h3,
        AWT_STAB       = 3'h2,
        AWT_HALT_PLAIN = 3'h6
    } awt_state_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } awt_apb_req_type;

endpackage

// ### rtl/awt_wake_timer.sv
// Auto wake-up from halt timer with APB register access.
// Notes on behaviour
// [RULE1] Halt with enable set enters timed halt wake.
// [RULE2] Entry starts RC oscillator, divider, then prescaler.
// [RULE3] Halt lasts 64 times prescale RC periods plus startup.
// [RULE4] Expiry sets flag, interrupt, oscillator, 64-cycle wait.
// [RULE5] After stabilisation resume at wake interrupt vector.
// [RULE6] Reading control register clears flag and interrupt.
// [RULE7] Flag bit 2 is read only.
// [RULE8] Measure bit routes RC clock to capture.
// [RULE9] Enable bit 0 is software controlled.
// [RULE10] Control bits 7 to 3 read zero.
// [RULE11] Prescale value is the dividing factor, 00h forbidden.
// [RULE12] Writing 00h keeps the previous prescale value.
// [RULE13] Reset values FFh prescale, 00h control.
// [RULE14] Reset or any halt-exit interrupt ends the mode.
// [RULE15] Entry clears the interrupt mask bit.
// [RULE16] Main oscillator and peripheral clocks stop in halt.
// [RULE17] Watchdog halt option may turn halt into reset.
// [RULE18] Opcode 8Eh decodes as halt.
// [RULE19] Divider and prescaler restart on each entry.
module awt_wake_timer
    import awt_pkg::*;
#(
    parameter int RC_START_CYCLES = AWT_RC_START_CYC
) (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            nrst_i,
    // APB slave
    input  wire awt_apb_req_type apb_req_i,
    output logic [31:0]          prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    // CPU core
    input  wire logic [7:0]      fetch_opcode_i,
    input  wire logic            fetch_valid_i,
    input  wire logic            halt_exit_irq_i,
    output logic                 cpu_run_o,
    output logic                 irq_mask_clear_o,
    output logic                 wake_irq_o,
    output logic                 wake_vector_o,
    // Watchdog and option
    input  wire logic            watchdog_enabled_i,
    input  wire logic            watchdog_halt_option_i,
    output logic                 watchdog_reset_o,
    // Clocks and oscillators
    input  wire logic            rc_clk_i,
    output logic                 rc_osc_en_o,
    output logic                 main_osc_en_o,
    output logic                 periph_clk_en_o,
    output logic                 lt_capture_o,
    // Interrupt
    output logic                 irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    awt_state_type state;
    awt_state_type next_state;
    logic [7:0]    prescale;
    logic          timer_enable;
    logic          osc_measure;
    logic          event_flag;
    logic [2:0]    irq_status;
    logic [2:0]    irq_mask;
    logic          rc_clk_q;
    logic [5:0]    div_cnt;
    logic [7:0]    presc_cnt;
    logic [15:0]   start_cnt;
    logic [6:0]    stab_cnt;
    logic          woke_by_timer;
    logic [31:0]   next_prdata;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire setup_phase  = apb_req_i.psel & ~apb_req_i.penable;
    wire access_phase = apb_req_i.psel & apb_req_i.penable;
    wire sel_prescale = apb_req_i.paddr == AWT_ADDR_PRESCALE;
    wire sel_ctrl     = apb_req_i.paddr == AWT_ADDR_CTRL_STATUS;
    wire sel_irq_st   = apb_req_i.paddr == AWT_ADDR_IRQ_STATUS;
    wire sel_irq_mask = apb_req_i.paddr == AWT_ADDR_IRQ_MASK;
    wire sel_any      = sel_prescale | sel_ctrl | sel_irq_st | sel_irq_mask;
    wire wr_access    = access_phase & apb_req_i.pwrite & sel_any;
    wire wr_prescale  = wr_access & sel_prescale;
    wire wr_ctrl      = wr_access & sel_ctrl;
    wire wr_irq_st    = wr_access & sel_irq_st;
    wire wr_irq_mask  = wr_access & sel_irq_mask;
    wire rd_ctrl      = access_phase & ~apb_req_i.pwrite & sel_ctrl;
    wire [7:0] wbyte  = apb_req_i.pwdata[7:0];
    wire prescale_ok  = wbyte != AWT_PRESCALE_BAD;    // see [RULE12]

    // Control byte with reserved bits at zero.
    wire [7:0] ctrl_byte = {5'h00, event_flag, osc_measure, timer_enable};    // see [RULE10]

    assign pready_o = 1'b1;

    // ------------------------------------------------------------------
    // Halt decode and mode selection
    // ------------------------------------------------------------------
    wire halt_exec   = fetch_valid_i & (fetch_opcode_i == AWT_HALT_OPCODE) & (state == AWT_RUN);    // see [RULE18]
    wire wdg_trip    = halt_exec & watchdog_enabled_i & ~watchdog_halt_option_i;    // see [RULE17]
    wire enter_timed = halt_exec & ~wdg_trip & timer_enable;    // see [RULE1]
    wire enter_plain = halt_exec & ~wdg_trip & ~timer_enable;

    // ------------------------------------------------------------------
    // Wake counting
    // ------------------------------------------------------------------
    wire       rc_rise     = rc_clk_i & ~rc_clk_q;
    wire       div_tick    = (state == AWT_COUNT) & rc_rise & (div_cnt == AWT_DIV_LAST);    // see [RULE2]
    wire [7:0] presc_plus  = presc_cnt + 8'h01;
    wire       expire      = div_tick & (presc_plus == prescale);    // see [RULE3] [RULE11]
    wire       start_done  = start_cnt == 16'(RC_START_CYCLES - 1);
    wire       stab_done   = stab_cnt == 7'(AWT_STAB_CYCLES - 1);
    wire       early_wake  = halt_exit_irq_i & ((state == AWT_RC_START) | (state == AWT_COUNT));    // see [RULE14]
    wire       plain_wake  = halt_exit_irq_i & (state == AWT_HALT_PLAIN);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            AWT_RUN: begin
                if (enter_timed) begin
                    next_state = AWT_RC_START;
                end else if (enter_plain) begin
                    next_state = AWT_HALT_PLAIN;
                end
            end
            AWT_RC_START: begin
                if (early_wake) begin
                    next_state = AWT_STAB;
                end else if (start_done) begin
                    next_state = AWT_COUNT;
                end
            end
            AWT_COUNT: begin
                if (early_wake | expire) begin
                    next_state = AWT_STAB;    // see [RULE4]
                end
            end
            AWT_STAB: begin
                if (stab_done) begin
                    next_state = AWT_RUN;
                end
            end
            AWT_HALT_PLAIN: begin
                if (plain_wake) begin
                    next_state = AWT_STAB;
                end
            end
            default: begin
                next_state = AWT_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (1'b1)
            sel_prescale: next_prdata = {24'h000000, prescale};
            sel_ctrl:     next_prdata = {24'h000000, ctrl_byte};
            sel_irq_st:   next_prdata = {29'h00000000, irq_status};
            sel_irq_mask: next_prdata = {29'h00000000, irq_mask};
            default:      next_prdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= AWT_RUN;
            rc_clk_q <= 1'b0;
        end else begin
            state    <= next_state;
            rc_clk_q <= rc_clk_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt   <= 6'h00;
            presc_cnt <= 8'h00;
        end else if (state != AWT_COUNT) begin
            div_cnt   <= 6'h00;    // see [RULE19]
            presc_cnt <= 8'h00;
        end else if (rc_rise) begin
            div_cnt <= div_cnt + 6'h01;
            if (div_cnt == AWT_DIV_LAST) begin
                presc_cnt <= presc_plus;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_cnt <= 16'h0000;
        end else if (state == AWT_RC_START) begin
            start_cnt <= start_cnt + 16'h0001;    // see [RULE3]
        end else begin
            start_cnt <= 16'h0000;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stab_cnt <= 7'h00;
        end else if (state == AWT_STAB) begin
            stab_cnt <= stab_cnt + 7'h01;    // see [RULE4]
        end else begin
            stab_cnt <= 7'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            woke_by_timer <= 1'b0;
        end else if (expire) begin
            woke_by_timer <= 1'b1;
        end else if (state == AWT_RUN) begin
            woke_by_timer <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prescale <= AWT_RST_PRESCALE;    // see [RULE13]
        end else if (wr_prescale & prescale_ok) begin
            prescale <= wbyte;    // see [RULE11] [RULE12]
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_enable <= AWT_RST_CTRL[AWT_BIT_ENABLE];    // see [RULE13]
            osc_measure  <= AWT_RST_CTRL[AWT_BIT_MEASURE];
        end else if (wr_ctrl) begin
            timer_enable <= wbyte[AWT_BIT_ENABLE];    // see [RULE9]
            osc_measure  <= wbyte[AWT_BIT_MEASURE];
        end
    end

    // Flag ignores writes; set wins over the clearing read.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            event_flag <= AWT_RST_CTRL[AWT_BIT_FLAG];
        end else if (expire) begin
            event_flag <= 1'b1;    // see [RULE4] [RULE7]
        end else if (rd_ctrl) begin
            event_flag <= 1'b0;    // see [RULE6]
        end
    end

    wire [2:0] irq_set = {wdg_trip, early_wake, expire};

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_status <= AWT_RST_IRQ;
            irq_mask   <= AWT_RST_IRQ;
        end else begin
            irq_status <= irq_set | (irq_status & ~(wr_irq_st ? wbyte[2:0] : 3'h0));
            if (wr_irq_mask) begin
                irq_mask <= wbyte[2:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup_phase) begin
            prdata_o  <= next_prdata;
            pslverr_o <= ~sel_any;
        end
    end

    // ------------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask_clear_o <= 1'b0;
            watchdog_reset_o <= 1'b0;
            wake_vector_o    <= 1'b0;
            lt_capture_o     <= 1'b0;
        end else begin
            irq_mask_clear_o <= enter_timed | enter_plain;    // see [RULE15]
            watchdog_reset_o <= wdg_trip;    // see [RULE17]
            wake_vector_o    <= (state == AWT_STAB) & stab_done & woke_by_timer & event_flag;    // see [RULE5]
            lt_capture_o     <= (state == AWT_RUN) & osc_measure & rc_clk_i;    // see [RULE8]
        end
    end

    assign wake_irq_o      = event_flag;    // see [RULE4] [RULE6]
    assign cpu_run_o       = state == AWT_RUN;
    assign main_osc_en_o   = (state == AWT_RUN) | (state == AWT_STAB);    // see [RULE16]
    assign periph_clk_en_o = state == AWT_RUN;    // see [RULE16]
    assign rc_osc_en_o     = (state == AWT_RC_START) | (state == AWT_COUNT)
                           | ((state == AWT_RUN) & osc_measure);    // see [RULE2] [RULE8]
    assign irq_o           = |(irq_status & irq_mask);

endmodule

// ### testbench/awt_monitor.sv
// Checker of the wake timer port behaviour.
module awt_monitor
    import awt_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            nrst_i,
    // Bus and CPU side
    input  wire awt_apb_req_type apb_req_i,
    input  wire logic [31:0]     prdata_o,
    input  wire logic            pready_o,
    input  wire logic [7:0]      fetch_opcode_i,
    input  wire logic            fetch_valid_i,
    input  wire logic            halt_exit_irq_i,
    input  wire logic            cpu_run_o,
    input  wire logic            irq_mask_clear_o,
    input  wire logic            wake_irq_o,
    input  wire logic            wake_vector_o,
    input  wire logic            watchdog_enabled_i,
    input  wire logic            watchdog_halt_option_i,
    input  wire logic            watchdog_reset_o,
    // Clocks
    input  wire logic            rc_clk_i,
    input  wire logic            rc_osc_en_o,
    input  wire logic            main_osc_en_o,
    input  wire logic            periph_clk_en_o,
    input  wire logic            lt_capture_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] stab_cnt;
    wire        halt_go  = fetch_valid_i && fetch_opcode_i == AWT_HALT_OPCODE && cpu_run_o;
    wire        wdg_trip = watchdog_enabled_i && !watchdog_halt_option_i;
    wire        ctrl_rd  = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite;
    // Counts the cycles of the stabilisation wait.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stab_cnt <= 8'h00;
        end else if (cpu_run_o || !main_osc_en_o) begin
            stab_cnt <= 8'h00;
        end else begin
            stab_cnt <= stab_cnt + 8'h01;
        end
    end
    property p_halt_entry;
        halt_go && !wdg_trip |=> irq_mask_clear_o && !cpu_run_o;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");
    property p_wdg;
        halt_go && wdg_trip |=> watchdog_reset_o && cpu_run_o;
    endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog halt wrong");
    property p_clocks;
        !cpu_run_o |-> !periph_clk_en_o && !(rc_osc_en_o && main_osc_en_o);
    endproperty
    a_clocks: assert property (p_clocks) else $error("clocks in halt wrong");
    property p_flag;
        $rose(wake_irq_o) |-> main_osc_en_o && !cpu_run_o;
    endproperty
    a_flag: assert property (p_flag) else $error("flag set wrong");
    property p_stab;
        $rose(cpu_run_o) |-> stab_cnt == 8'h40;
    endproperty
    a_stab: assert property (p_stab) else $error("stabilisation wrong");
    property p_vector;
        wake_vector_o |-> cpu_run_o && wake_irq_o;
    endproperty
    a_vector: assert property (p_vector) else $error("wake vector wrong");
    property p_exit;
        halt_exit_irq_i && !main_osc_en_o |=> main_osc_en_o;
    endproperty
    a_exit: assert property (p_exit) else $error("halt exit wrong");
    property p_capture;
        lt_capture_o |-> $past(rc_clk_i) && $past(cpu_run_o);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");
    property p_rsvd;
        ctrl_rd && apb_req_i.paddr == AWT_ADDR_CTRL_STATUS |-> prdata_o[7:3] == 5'h00 && pready_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
endmodule

bind awt_wake_timer awt_monitor u_mon (.core_clk_i, .nrst_i, .apb_req_i, .prdata_o, .pready_o, .fetch_opcode_i,
    .fetch_valid_i, .halt_exit_irq_i, .cpu_run_o, .irq_mask_clear_o, .wake_irq_o, .wake_vector_o,
    .watchdog_enabled_i, .watchdog_halt_option_i, .watchdog_reset_o, .rc_clk_i, .rc_osc_en_o,
    .main_osc_en_o, .periph_clk_en_o, .lt_capture_o);

// ### testbench/awt_rc_model.sv
// Model of the wake RC oscillator seen by the timer.
module awt_rc_model (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    // Oscillator
    input  wire logic osc_en_i,
    output logic      rc_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph;
    // Runs at a quarter of the core rate and stands low while off.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph       <= 2'h0;
            rc_clk_o <= 1'b0;
        end else if (!osc_en_i) begin
            ph       <= 2'h0;
            rc_clk_o <= 1'b0;
        end else begin
            ph       <= ph + 2'h1;
            rc_clk_o <= ph[1];
        end
    end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench of the wake timer.
`define CHK(g, e) chk(32'(g), 32'(e));
module tb_top
    import awt_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic            core_clk_i, pready, pslverr, run, mclr, wirq, wvec, wrst, rc_en, mosc, pclk, ltc, irq, rc_clk;
    logic            nrst_i = 1'b0, fv = 1'b0, hexi = 1'b0, wen = 1'b0, wopt = 1'b1;
    logic [7:0]      opc = 8'h00;
    logic [31:0]     prdata;
    awt_apb_req_type req = '0;
    int              err_count = 0, n_checks = 0, m_presc = 255, m_ctrl = 0, m_stat = 0, m_mask = 0;
    int              n, v, r, p, k, i;
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    awt_wake_timer #(.RC_START_CYCLES(2)) u_dut (.core_clk_i, .nrst_i, .apb_req_i(req), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fetch_opcode_i(opc), .fetch_valid_i(fv), .halt_exit_irq_i(hexi),
        .cpu_run_o(run), .irq_mask_clear_o(mclr), .wake_irq_o(wirq), .wake_vector_o(wvec),
        .watchdog_enabled_i(wen), .watchdog_halt_option_i(wopt), .watchdog_reset_o(wrst), .rc_clk_i(rc_clk),
        .rc_osc_en_o(rc_en), .main_osc_en_o(mosc), .periph_clk_en_o(pclk), .lt_capture_o(ltc), .irq_o(irq));
    awt_rc_model u_rc (.core_clk_i, .nrst_i, .osc_en_i(rc_en), .rc_clk_o(rc_clk));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int j;
        @(posedge core_clk_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk_i);
        req.penable <= 1'b1;
        for (j = 0; j < 20; j++) begin
            @(posedge core_clk_i);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (j == 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'($urandom), d}, q, e);
        if (a == AWT_ADDR_PRESCALE && d != AWT_PRESCALE_BAD) m_presc = d;
        if (a == AWT_ADDR_CTRL_STATUS) m_ctrl = (m_ctrl & 4) | (d & 3);
        if (a == AWT_ADDR_IRQ_STATUS) m_stat = m_stat & ~int'(d);
        if (a == AWT_ADDR_IRQ_MASK) m_mask = d & 7;
    endtask
    task automatic reg_rd(input logic [11:0] a);
        logic [31:0] q;
        logic        e;
        int          x;
        apb(1'b0, a, 32'h0, q, e);
        x = a == AWT_ADDR_PRESCALE ? m_presc : a == AWT_ADDR_CTRL_STATUS ? m_ctrl :
            a == AWT_ADDR_IRQ_STATUS ? m_stat : a == AWT_ADDR_IRQ_MASK ? m_mask : 0;
        `CHK(q, x)
        `CHK(e, !(a inside {AWT_ADDR_PRESCALE, AWT_ADDR_CTRL_STATUS, AWT_ADDR_IRQ_STATUS, AWT_ADDR_IRQ_MASK}))
        if (a == AWT_ADDR_CTRL_STATUS) m_ctrl = m_ctrl & 3;
    endtask
    task automatic st;
        @(negedge core_clk_i);
        `CHK(wirq, (m_ctrl >> 2) & 1)
        `CHK(irq, (m_stat & m_mask) != 0)
    endtask
    task automatic do_halt(input logic [7:0] op, input int early);
        @(posedge core_clk_i);
        opc <= op;
        fv <= 1'b1;
        @(posedge core_clk_i);
        fv <= 1'b0;
        @(negedge core_clk_i);
        r = rc_en;
        n = 0;
        v = 0;
        while (run !== 1'b1 && n < 5000) begin
            if (n == early) begin
                @(posedge core_clk_i);
                hexi <= 1'b1;
            end
            @(negedge core_clk_i);
            n++;
            if (wvec === 1'b1) v = 1;
        end
        @(posedge core_clk_i);
        hexi <= 1'b0;
        if (n == 5000) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(64));
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        reg_rd(AWT_ADDR_PRESCALE);
        reg_rd(AWT_ADDR_CTRL_STATUS);
        reg_rd(12'h200);
        reg_wr(AWT_ADDR_CTRL_STATUS, 8'hFF);
        reg_rd(AWT_ADDR_CTRL_STATUS);
        reg_wr(AWT_ADDR_PRESCALE, 8'h00);
        reg_rd(AWT_ADDR_PRESCALE);
        reg_wr(AWT_ADDR_CTRL_STATUS, 8'h02);
        k = 0;
        repeat (40) begin
            @(negedge core_clk_i);
            if (ltc === 1'b1) k++;
        end
        `CHK(k > 10 && k < 30, 1)
        `CHK(rc_en, 1)
        p = 1 + $urandom % 2;
        reg_wr(AWT_ADDR_PRESCALE, 8'(p));
        reg_rd(AWT_ADDR_PRESCALE);
        reg_wr(AWT_ADDR_IRQ_MASK, 8'h07);
        reg_wr(AWT_ADDR_CTRL_STATUS, 8'h01);
        repeat (2) @(negedge core_clk_i);
        `CHK(ltc, 0)
        for (i = 0; i < 2; i++) begin
            do_halt(AWT_HALT_OPCODE, -1);
            m_ctrl = 5;
            m_stat = m_stat | 1;
            `CHK(r, 1)
            `CHK(n > 256 * p + 60 && n < 256 * p + 67, 1)
            `CHK(v, 1)
            st();
            reg_rd(AWT_ADDR_CTRL_STATUS);
            st();
        end
        reg_rd(AWT_ADDR_IRQ_STATUS);
        reg_wr(AWT_ADDR_IRQ_MASK, 8'h00);
        st();
        reg_wr(AWT_ADDR_IRQ_MASK, 8'h07);
        reg_wr(AWT_ADDR_IRQ_STATUS, 8'h01);
        st();
        do_halt(AWT_HALT_OPCODE, 10);
        m_stat = m_stat | 2;
        `CHK(n < 90 && v == 0, 1)
        st();
        reg_wr(AWT_ADDR_CTRL_STATUS, 8'h00);
        do_halt(AWT_HALT_OPCODE, 10);
        `CHK(r == 0 && n < 90, 1)
        @(posedge core_clk_i);
        wen <= 1'b1;
        wopt <= 1'b0;
        do_halt(AWT_HALT_OPCODE, -1);
        m_stat = m_stat | 4;
        `CHK(n, 0)
        reg_rd(AWT_ADDR_IRQ_STATUS);
        wen <= 1'b0;
        do_halt(8'($urandom % 141), -1);
        `CHK(n, 0)
        reg_wr(AWT_ADDR_IRQ_STATUS, 8'h07);
        st();
        tally_and_finish();
    end
endmodule
